// ==== hdl/scp_cfg.svh ====
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

`define SCP_FRAME_BITS     5'h10
`define SCP_CNT_MAX        5'h1f
`define SCP_STAT_REGS      10
`define SCP_ADDR_NONE_LO   7'h00
`define SCP_ADDR_NONE_HI   7'h7f
`define SCP_ADDR_MS        7'h01
`define SCP_ADDR_BOOST     7'h02
`define SCP_ADDR_WD        7'h03
`define SCP_ADDR_SUPPLY    7'h0e
`define SCP_ADDR_RO_A      7'h3a
`define SCP_ADDR_RO_B      7'h3b
`define SCP_ADDR_STAT_BASE 7'h40
`define SCP_ADDR_DEV_STAT  7'h43
`define SCP_MS_MODE_HI     7
`define SCP_MS_MODE_LO     6
`define SCP_MS_OTHER_HI    5
`define SCP_MS_IO_OV       3
`define SCP_MS_IO_RT_HI    1
`define SCP_MS_IO_RT_LO    0
`define SCP_MS_NORMAL      2'h0
`define SCP_MS_SLEEP       2'h1
`define SCP_MS_STOP        2'h2
`define SCP_MS_SOFT_RESET  2'h3
`define SCP_BOOST_EN       7
`define SCP_BOOST_V_HI     1
`define SCP_BOOST_V_LO     0
`define SCP_SUP_EXT_ON     0
`define SCP_SUP_AUX_HI     2
`define SCP_SUP_AUX_LO     1
`define SCP_DEV_REJECT_BIT 1
`define SCP_SYS_CLK_MHZ    50
`define SCP_INT_PULSE_NS   1000
`define SCP_INT_PULSE_CYC  ((`SCP_INT_PULSE_NS * `SCP_SYS_CLK_MHZ) / 1000)

`endif

// ==== hdl/scp_pkg.sv ====
package scp_pkg;

  typedef enum logic [2:0] {
    scp_m_init,
    scp_m_normal,
    scp_m_stop,
    scp_m_sleep,
    scp_m_restart,
    scp_m_failsafe,
    scp_m_soft_reset
  } scp_mode_type;

endpackage

// ==== hdl/scp_command_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"

module scp_command_port
  import scp_pkg::*;
(
  input  wire logic          sys_clk_in,                 // system clock, 50 MHz
  input  wire logic          arst_n_in,                  // async reset, active low
  input  wire logic          spi_clk_in,                 // serial clock from master
  input  wire logic          chip_select_low_n_in,       // chip select, active low
  input  wire logic          spi_data_in,                // serial data from master
  output logic               spi_data_out,               // serial data to master
  output logic               spi_data_oe_n_out,          // serial output enable, low drives
  input  wire logic          reset_output_pin_n_in,      // level of the reset pin
  input  wire scp_mode_type  device_mode_in,             // present device mode
  input  wire logic [79:0]   status_regs_in,             // ten status registers
  input  wire logic [31:0]   wake_sources_in,            // bus/wake control registers
  input  wire logic [7:0]    rd_data_in,                 // present value at rd_addr_out
  output logic [6:0]         rd_addr_out,                // address of the frame
  output logic               wr_strobe_out,              // control write pulse
  output logic [6:0]         wr_addr_out,                // control write address
  output logic [7:0]         wr_data_out,                // control write data
  output logic               clr_strobe_out,             // status clear pulse
  output logic [6:0]         clr_addr_out,               // status clear address
  output logic               mode_req_strobe_out,        // mode request pulse
  output scp_mode_type       mode_req_out,               // requested mode
  output logic               command_reject_flag_out,    // sticky reject flag
  output logic               protocol_fault_flag_out,    // last frame faulty
  output logic               interrupt_pin_n_out,        // interrupt pin, active low
  output logic [7:0]         status_summary_byte_out     // compressed status
);

  // ---------------- link clock domain ----------------
  logic         spi_rst_n;
  logic         tgl_q;
  logic [4:0]   fidx_q;
  logic [15:0]  rx_q;
  logic [4:0]   ridx_q;
  logic         bit_q;
  logic [15:0]  tx_word;
  logic [7:0]   rd_byte;

  // frame position counters restart while select is high
  assign spi_rst_n = arst_n_in & ~chip_select_low_n_in;

  always_ff @(negedge spi_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tgl_q <= 1'b0;
    end else begin
      tgl_q <= ~tgl_q;
    end
  end

  always_ff @(negedge spi_clk_in or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      fidx_q <= 5'h00;
    end else if (fidx_q != `SCP_CNT_MAX) begin
      fidx_q <= fidx_q + 5'h01;
    end
  end

  always_ff @(negedge spi_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_q <= 16'h0000;
    end else if (fidx_q < `SCP_FRAME_BITS) begin
      rx_q[fidx_q[3:0]] <= spi_data_in;
    end
  end

  assign rd_addr_out = rx_q[6:0];

  always_ff @(posedge spi_clk_in or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      ridx_q <= 5'h00;
      bit_q  <= 1'b0;
    end else begin
      if (ridx_q != `SCP_CNT_MAX) begin
        ridx_q <= ridx_q + 5'h01;
      end
      bit_q <= (ridx_q < `SCP_FRAME_BITS) ? tx_word[ridx_q[3:0]] : 1'b0;
    end
  end

  // ---------------- system clock domain ----------------
  logic         cs_s1_q, cs_s2_q, cs_s3_q;
  logic         sck_s1_q, sck_s2_q;
  logic         rst_s1_q, rst_s2_q;
  logic         tg_s1_q, tg_s2_q, tg_s3_q;
  logic         frame_start, frame_end, in_frame, tgl_chg;
  logic [4:0]   cnt_q, cnt_fin;
  logic         clk_err_q, rst_ovl_q;
  logic         fault_q, reject_q, lock_q;
  logic [7:0]   summary_q;
  logic [`SCP_STAT_REGS-1:0] reg_nz;
  logic [7:0]   summary;
  logic         bad_frame, good_frame, stuck, interp, wake_pending;
  logic [6:0]   addr;
  logic         acc;
  logic [7:0]   dat;
  logic         do_w, do_clr, do_rej, do_mreq, do_int;
  logic [7:0]   wd;
  scp_mode_type mval;
  logic [15:0]  int_cnt_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      tg_s1_q  <= 1'b0;
      tg_s2_q  <= 1'b0;
      tg_s3_q  <= 1'b0;
    end else begin
      cs_s1_q  <= chip_select_low_n_in;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      sck_s1_q <= spi_clk_in;
      sck_s2_q <= sck_s1_q;
      rst_s1_q <= reset_output_pin_n_in;
      rst_s2_q <= rst_s1_q;
      tg_s1_q  <= tgl_q;
      tg_s2_q  <= tg_s1_q;
      tg_s3_q  <= tg_s2_q;
    end
  end

  assign frame_start = cs_s3_q & ~cs_s2_q;
  assign frame_end   = ~cs_s3_q & cs_s2_q;
  assign in_frame    = ~cs_s2_q;
  assign tgl_chg     = tg_s3_q ^ tg_s2_q;
  // last falling clock may still be in the synchroniser at release
  assign cnt_fin     = (tgl_chg && cnt_q != `SCP_CNT_MAX) ? cnt_q + 5'h01 : cnt_q;

  // falling clocks per frame, saturating
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= 5'h00;
    end else if (frame_start) begin
      cnt_q <= 5'h00;
    end else if (in_frame || frame_end) begin
      cnt_q <= cnt_fin;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_err_q <= 1'b0;
      rst_ovl_q <= 1'b0;
    end else if (frame_start) begin
      clk_err_q <= sck_s2_q;
      rst_ovl_q <= ~rst_s2_q;
    end else if (in_frame) begin
      rst_ovl_q <= rst_ovl_q | ~rst_s2_q;
    end
  end

  assign bad_frame = (cnt_fin != 5'h00 && cnt_fin != `SCP_FRAME_BITS)
                   | clk_err_q | sck_s2_q | rst_ovl_q | ~rst_s2_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_q <= 1'b0;
    end else if (frame_end) begin
      fault_q <= bad_frame;
    end
  end

  assign protocol_fault_flag_out = fault_q;

  // per-register nonzero detect
  genvar gi;
  generate
    for (gi = 0; gi < `SCP_STAT_REGS; gi = gi + 1) begin : g_nz
      assign reg_nz[gi] = |status_regs_in[gi*8 +: 8];
    end
  endgenerate

  assign summary = {reg_nz[9], reg_nz[8], reg_nz[7], reg_nz[6] | reg_nz[5], reg_nz[4],
                    reg_nz[3] | reject_q, reg_nz[2], reg_nz[1] | reg_nz[0]};

  // frozen while selected so the shifted byte stays coherent
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      summary_q <= 8'h00;
    end else if (!in_frame) begin
      summary_q <= summary;
    end
  end

  assign status_summary_byte_out = summary_q;

  assign rd_byte = (rd_addr_out == `SCP_ADDR_DEV_STAT)
                 ? (rd_data_in | ({7'h00, reject_q} << `SCP_DEV_REJECT_BIT)) : rd_data_in;
  assign tx_word = {rd_byte, summary_q};

  // fault bit shows before the first rising clock, then the word
  assign spi_data_out      = ~rst_s2_q | ((ridx_q == 5'h00) ? fault_q : bit_q);
  assign spi_data_oe_n_out = cs_s2_q;

  // ---------------- command decode ----------------
  assign addr         = rx_q[6:0];
  assign acc          = rx_q[7];
  assign dat          = rx_q[15:8];
  // a frame without clocks only reports the fault bit; the receive
  // register still holds the previous word, which must not run again
  assign good_frame   = frame_end & ~bad_frame
                      & (cnt_fin == `SCP_FRAME_BITS);
  // a data line stuck at one level fills the word with a single value
  assign stuck        = (rx_q == 16'h0000) | (rx_q == 16'hffff);
  assign interp       = good_frame & ~stuck & (device_mode_in != scp_m_restart)
                      & (device_mode_in != scp_m_sleep)
                      & (device_mode_in != scp_m_failsafe);
  assign wake_pending = reg_nz[7] | reg_nz[8];

  always_comb begin
    do_w    = 1'b0;
    do_clr  = 1'b0;
    do_rej  = 1'b0;
    do_mreq = 1'b0;
    do_int  = 1'b0;
    wd      = dat;
    mval    = device_mode_in;
    if (good_frame && stuck) begin
      do_rej = 1'b1;
    end else if (interp && acc) begin
      if (addr >= `SCP_ADDR_STAT_BASE && addr != `SCP_ADDR_NONE_HI) begin
        do_clr = 1'b1;
      end else if (addr == `SCP_ADDR_NONE_LO || addr == `SCP_ADDR_NONE_HI
                   || addr == `SCP_ADDR_RO_A || addr == `SCP_ADDR_RO_B) begin
        do_rej = 1'b1;
      end else if (addr == `SCP_ADDR_WD && ^dat) begin
        do_rej = 1'b1;
      end else if (device_mode_in == scp_m_stop) begin
        if (addr == `SCP_ADDR_WD) begin
          do_w = 1'b1;
        end else if (addr == `SCP_ADDR_MS) begin
          unique case (dat[`SCP_MS_MODE_HI:`SCP_MS_MODE_LO])
            `SCP_MS_NORMAL, `SCP_MS_STOP: begin
              if (dat[`SCP_MS_OTHER_HI:0] != rd_data_in[`SCP_MS_OTHER_HI:0]) begin
                do_rej = (dat[`SCP_MS_IO_OV] != rd_data_in[`SCP_MS_IO_OV])
                       | (dat[`SCP_MS_IO_RT_HI:`SCP_MS_IO_RT_LO]
                          != rd_data_in[`SCP_MS_IO_RT_HI:`SCP_MS_IO_RT_LO]);
              end else begin
                do_w    = 1'b1;
                do_mreq = 1'b1;
                mval    = (dat[`SCP_MS_MODE_HI:`SCP_MS_MODE_LO] == `SCP_MS_NORMAL)
                        ? scp_m_normal : scp_m_stop;
              end
            end
            `SCP_MS_SOFT_RESET: begin
              do_mreq = 1'b1;
              mval    = scp_m_soft_reset;
            end
            `SCP_MS_SLEEP: begin
              do_rej  = 1'b1;
              do_mreq = 1'b1;
              mval    = scp_m_restart;
            end
          endcase
        end else begin
          do_rej = 1'b1;
        end
      end else if (addr == `SCP_ADDR_MS) begin
        do_w    = 1'b1;
        do_mreq = 1'b1;
        unique case (dat[`SCP_MS_MODE_HI:`SCP_MS_MODE_LO])
          `SCP_MS_NORMAL: begin
            mval = scp_m_normal;
          end
          `SCP_MS_SOFT_RESET: begin
            mval = scp_m_soft_reset;
          end
          `SCP_MS_STOP, `SCP_MS_SLEEP: begin
            if (device_mode_in == scp_m_init) begin
              do_rej = 1'b1;
              mval   = scp_m_normal;
              wd[`SCP_MS_MODE_HI:`SCP_MS_MODE_LO] = `SCP_MS_NORMAL;
            end else if (dat[`SCP_MS_MODE_HI:`SCP_MS_MODE_LO] == `SCP_MS_STOP) begin
              mval   = scp_m_stop;
              do_int = wake_pending;
            end else if (wake_sources_in == 32'h0000_0000) begin
              do_rej = 1'b1;
              mval   = scp_m_restart;
            end else begin
              mval = scp_m_sleep;
            end
          end
        endcase
      end else if (addr == `SCP_ADDR_BOOST && rd_data_in[`SCP_BOOST_EN]
                   && dat[`SCP_BOOST_V_HI:`SCP_BOOST_V_LO]
                      != rd_data_in[`SCP_BOOST_V_HI:`SCP_BOOST_V_LO]) begin
        do_rej = 1'b1;
      end else begin
        do_w = 1'b1;
        if (addr == `SCP_ADDR_SUPPLY && lock_q) begin
          wd[`SCP_SUP_AUX_HI:`SCP_SUP_AUX_LO] =
            rd_data_in[`SCP_SUP_AUX_HI:`SCP_SUP_AUX_LO];
        end
      end
    end
  end

  // strobes pulse for one cycle, address and data hold until replaced
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_strobe_out       <= 1'b0;
      wr_addr_out         <= 7'h00;
      wr_data_out         <= 8'h00;
      clr_strobe_out      <= 1'b0;
      clr_addr_out        <= 7'h00;
      mode_req_strobe_out <= 1'b0;
      mode_req_out        <= scp_m_init;
    end else begin
      wr_strobe_out       <= do_w;
      clr_strobe_out      <= do_clr;
      mode_req_strobe_out <= do_mreq;
      if (do_w) begin
        wr_addr_out <= addr;
        wr_data_out <= wd;
      end
      if (do_clr) begin
        clr_addr_out <= addr;
      end
      if (do_mreq) begin
        mode_req_out <= mval;
      end
    end
  end

  // set wins over a clearing write in the same cycle
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reject_q <= 1'b0;
    end else if (do_rej) begin
      reject_q <= 1'b1;
    end else if (do_clr && addr == `SCP_ADDR_DEV_STAT) begin
      reject_q <= 1'b0;
    end
  end

  assign command_reject_flag_out = reject_q;

  // first supply-on write freezes the aux voltage select for good
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lock_q <= 1'b0;
    end else if (do_w && addr == `SCP_ADDR_SUPPLY && wd[`SCP_SUP_EXT_ON]) begin
      lock_q <= 1'b1;
    end
  end

  // fixed-length interrupt pulse, restarted by a new stop entry
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      int_cnt_q <= 16'h0000;
    end else if (do_int) begin
      int_cnt_q <= 16'(`SCP_INT_PULSE_CYC);
    end else if (int_cnt_q != 16'h0000) begin
      int_cnt_q <= int_cnt_q - 16'h0001;
    end
  end

  assign interrupt_pin_n_out = (int_cnt_q == 16'h0000);

endmodule

`default_nettype wire

// ==== verif/scp_command_port_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
module scp_command_port_checker
  import scp_pkg::*;
(
  input wire logic         sys_clk_in,              // clock
  input wire logic         arst_n_in,               // reset
  input wire logic         chip_select_low_n_in,    // select
  input wire logic         spi_data_out,            // serial out
  input wire logic         spi_data_oe_n_out,       // out enable
  input wire logic         reset_output_pin_n_in,   // reset pin
  input wire scp_mode_type device_mode_in,          // mode
  input wire logic [79:0]  status_regs_in,          // status
  input wire logic         wr_strobe_out,           // write pulse
  input wire logic         clr_strobe_out,          // clear pulse
  input wire logic [6:0]   clr_addr_out,            // clear addr
  input wire logic         mode_req_strobe_out,     // mode pulse
  input wire scp_mode_type mode_req_out,            // mode request
  input wire logic         command_reject_flag_out, // reject
  input wire logic         protocol_fault_flag_out, // fault
  input wire logic         interrupt_pin_n_out,     // interrupt
  input wire logic [7:0]   status_summary_byte_out  // summary
);
  logic [7:0] int_cnt_q;
  logic [7:0] sum_exp;
  assign sum_exp = {|status_regs_in[79:72], |status_regs_in[71:64], |status_regs_in[63:56],
                    |status_regs_in[55:40], |status_regs_in[39:32], 1'b0,
                    |status_regs_in[23:16], |status_regs_in[15:0]};
  // counts how long the interrupt has been low
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      int_cnt_q <= 8'h00;
    end else begin
      int_cnt_q <= interrupt_pin_n_out ? 8'h00 : int_cnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence frame_closed;
    $past(chip_select_low_n_in, 2) && $past(chip_select_low_n_in, 3);
  endsequence
  sequence sum_quiet;
    (chip_select_low_n_in && $stable(status_regs_in)) [*6];
  endsequence
  wr_after_sel_a: assert property (wr_strobe_out |-> frame_closed)
    else $error("write pulse while frame open");
  oe_release_a: assert property ($rose(chip_select_low_n_in) |-> ##[1:4] spi_data_oe_n_out)
    else $error("serial output not released");
  sdo_rst_high_a: assert property ((!reset_output_pin_n_in) [*3] |-> spi_data_out)
    else $error("serial output low during reset pin");
  rej_clear_a: assert property ($fell(command_reject_flag_out) |->
    (clr_strobe_out || $past(clr_strobe_out)) && clr_addr_out == `SCP_ADDR_DEV_STAT)
    else $error("reject flag cleared without clear command");
  rej_set_end_a: assert property ($rose(command_reject_flag_out) |-> frame_closed)
    else $error("reject flag set while frame open");
  idle_mode_a: assert property (wr_strobe_out |->
    !(device_mode_in inside {scp_m_restart, scp_m_sleep, scp_m_failsafe}))
    else $error("write taken in a non interpreting mode");
  fault_no_wr_a: assert property (wr_strobe_out |-> !protocol_fault_flag_out)
    else $error("faulty frame executed");
  fault_end_a: assert property ($changed(protocol_fault_flag_out) |-> frame_closed)
    else $error("fault flag changed while frame open");
  sleep_req_a: assert property (mode_req_strobe_out && mode_req_out == scp_m_sleep |->
    !(device_mode_in inside {scp_m_stop, scp_m_init}))
    else $error("illegal sleep request passed");
  int_pulse_a: assert property ($rose(interrupt_pin_n_out) |->
    int_cnt_q == `SCP_INT_PULSE_CYC)
    else $error("interrupt pulse length wrong");
  sum_or_a: assert property (sum_quiet |-> (status_summary_byte_out & 8'hfb) == sum_exp)
    else $error("summary byte differs from status");
endmodule
bind scp_command_port scp_command_port_checker chk (.sys_clk_in, .arst_n_in,
  .chip_select_low_n_in, .spi_data_out, .spi_data_oe_n_out, .reset_output_pin_n_in,
  .device_mode_in, .status_regs_in, .wr_strobe_out, .clr_strobe_out, .clr_addr_out,
  .mode_req_strobe_out, .mode_req_out, .command_reject_flag_out, .protocol_fault_flag_out,
  .interrupt_pin_n_out, .status_summary_byte_out);
`default_nettype wire

// ==== verif/scp_spi_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module scp_spi_master (
  output var logic spi_clk_out, // serial clock
  output var logic cs_n_out,    // select
  output var logic sdi_out,     // data to device
  input  wire logic sdo_in      // data from device
);
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // 80 ns clock, launched on rise, sampled on fall; lsb first
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] r, output logic f);
    r = 16'h0000;
    #3 cs_n_out = 1'b0;
    #80 f = sdo_in;
    for (int i = 0; i < n; i++) begin
      spi_clk_out = 1'b1;
      sdi_out = w[i % 16];
      #40 spi_clk_out = 1'b0;
      if (i < 16) r[i] = sdo_in;
      #40;
    end
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #100;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_sbc_spi_command_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_sbc_spi_command_port
  import scp_pkg::*;
;
  logic sys_clk_in, arst_n_in, reset_output_pin_n_in;
  wire logic spi_clk_in, chip_select_low_n_in, spi_data_in;
  scp_mode_type device_mode_in, mode_req_out;
  logic [79:0] status_regs_in;
  logic [31:0] wake_sources_in;
  logic [7:0] rd_data_in, wr_data_out, status_summary_byte_out;
  logic [6:0] rd_addr_out, wr_addr_out, clr_addr_out;
  logic spi_data_out, spi_data_oe_n_out, wr_strobe_out, clr_strobe_out, mode_req_strobe_out;
  logic command_reject_flag_out, protocol_fault_flag_out, interrupt_pin_n_out, flt;
  logic [15:0] resp;
  int error_cnt = 0, checks_done = 0, wr_n, clr_n, md_n;
  wire logic sdo_w = spi_data_oe_n_out ? 1'bz : spi_data_out;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
  scp_command_port uut (.sys_clk_in, .arst_n_in, .spi_clk_in, .chip_select_low_n_in,
    .spi_data_in, .spi_data_out, .spi_data_oe_n_out, .reset_output_pin_n_in, .device_mode_in,
    .status_regs_in, .wake_sources_in, .rd_data_in, .rd_addr_out, .wr_strobe_out,
    .wr_addr_out, .wr_data_out, .clr_strobe_out, .clr_addr_out, .mode_req_strobe_out,
    .mode_req_out, .command_reject_flag_out, .protocol_fault_flag_out, .interrupt_pin_n_out,
    .status_summary_byte_out);
  scp_spi_master mst (.spi_clk_out(spi_clk_in), .cs_n_out(chip_select_low_n_in),
    .sdi_out(spi_data_in), .sdo_in(sdo_w));
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    if (wr_strobe_out === 1'b1) wr_n++;
    if (clr_strobe_out === 1'b1) clr_n++;
    if (mode_req_strobe_out === 1'b1) md_n++;
  end
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic go(input logic [15:0] w, input int n = 16);
    wr_n = 0;
    clr_n = 0;
    md_n = 0;
    mst.xfer(w, n, resp, flt);
    repeat (3) @(negedge sys_clk_in);
  endtask
  task automatic clr();
    go(16'h00c3);
    `CHK(resp[9], 1'b1)
    `CHK(clr_n, 1)
    `CHK(command_reject_flag_out, 1'b0)
  endtask
  task automatic t_rw();
    go(16'h0382);
    `CHK({wr_n, wr_addr_out, wr_data_out}, {32'd1, 15'h0203})
    `CHK(rd_addr_out, 7'h02)
    `CHK(resp, 16'h5c84)
    go(16'h0302);
    `CHK(wr_n, 0)
  endtask
  task automatic t_reject(input logic [15:0] w, input logic [7:0] rd);
    rd_data_in = rd;
    go(w);
    `CHK({wr_n, command_reject_flag_out}, {32'd0, 1'b1})
    rd_data_in = 8'h5c;
    clr();
  endtask
  task automatic t_count();
    int n[2] = '{15, 17};
    for (int i = 0; i < 2; i++) begin
      go(16'h0382, n[i]);
      `CHK({wr_n, protocol_fault_flag_out}, {32'd0, 1'b1})
      go(16'h0302, 0);
      `CHK({wr_n, flt, protocol_fault_flag_out}, {32'd0, 2'b10})
    end
  endtask
  task automatic t_mode();
    scp_mode_type cur[4] = '{scp_m_init, scp_m_init, scp_m_stop, scp_m_normal};
    scp_mode_type exp[4] = '{scp_m_normal, scp_m_normal, scp_m_restart, scp_m_restart};
    logic [15:0] cmd[4] = '{16'h8081, 16'h4081, 16'h4081, 16'h4081};
    for (int i = 0; i < 4; i++) begin
      device_mode_in = cur[i];
      if (i == 3) wake_sources_in = 32'h00000000;
      go(cmd[i]);
      `CHK({md_n, mode_req_out, command_reject_flag_out}, {32'd1, exp[i], 1'b1})
      if (i == 3) `CHK(wr_n, 1)
      device_mode_in = scp_m_normal;
      wake_sources_in = 32'h00000001;
      clr();
    end
  endtask
  task automatic t_stop();
    go(16'h4081);
    `CHK({md_n, mode_req_out, command_reject_flag_out}, {32'd1, scp_m_sleep, 1'b0})
    device_mode_in = scp_m_stop;
    rd_data_in = 8'h80;
    go(16'h8981);
    `CHK({wr_n, md_n, command_reject_flag_out}, {64'd0, 1'b1})
    clr();
    go(16'ha081);
    `CHK({wr_n, md_n, command_reject_flag_out}, {64'd0, 1'b0})
    go(16'h1184);
    `CHK({wr_n, command_reject_flag_out}, {32'd0, 1'b1})
    clr();
    go(16'h0383);
    `CHK(wr_n, 1)
    device_mode_in = scp_m_normal;
    rd_data_in = 8'h00;
    go(16'h038e);
    `CHK({wr_n, wr_data_out}, {32'd1, 8'h03})
    go(16'h168e);
    `CHK({wr_n, wr_data_out}, {32'd1, 8'h10})
    rd_data_in = 8'h5c;
  endtask
  task automatic t_idle();
    scp_mode_type m[3] = '{scp_m_restart, scp_m_sleep, scp_m_failsafe};
    for (int i = 0; i < 3; i++) begin
      device_mode_in = m[i];
      go(16'h0382);
      `CHK(wr_n + md_n, 0)
    end
    device_mode_in = scp_m_normal;
  endtask
  task automatic t_rstpin();
    reset_output_pin_n_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    go(16'h0302);
    `CHK(resp, 16'hffff)
    reset_output_pin_n_in = 1'b1;
    go(16'h0302, 0);
    `CHK(flt, 1'b1)
  endtask
  task automatic t_intr();
    int k;
    status_regs_in[63:56] = 8'h01;
    go(16'h8081);
    `CHK({mode_req_out, command_reject_flag_out, interrupt_pin_n_out}, {scp_m_stop, 2'b00})
    for (k = 0; k < 60 && interrupt_pin_n_out !== 1'b1; k++) @(negedge sys_clk_in);
    if (k == 60) begin
      error_cnt++;
      $display("MISMATCH t=%0t interrupt pulse did not end", $time);
      tally_and_finish();
    end
    status_regs_in[63:56] = 8'h00;
  endtask
  initial begin
    arst_n_in = 1'b0;
    reset_output_pin_n_in = 1'b1;
    device_mode_in = scp_m_normal;
    status_regs_in = 80'h80_00_00_00_00_00_01_00_00_00;
    wake_sources_in = 32'h00000001;
    rd_data_in = 8'h5c;
    repeat (5) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    t_rw();
    t_reject(16'h8182, 8'h80);
    t_reject(16'h0183, 8'h5c);
    t_reject(16'hffff, 8'h5c);
    t_reject(16'h0000, 8'h5c);
    t_count();
    t_mode();
    t_stop();
    t_idle();
    t_rstpin();
    t_intr();
    tally_and_finish();
  end
endmodule
`default_nettype wire
